//--- verilog/rcp_defines.svh
// Register offsets, field positions, codec selections and character codes
`ifndef RCP_DEFINES_SVH
`define RCP_DEFINES_SVH
// Register byte offsets
`define RCP_REG_CTRL   5'h00
`define RCP_REG_STATUS 5'h04
`define RCP_REG_EVENT  5'h08
`define RCP_REG_UKEY   5'h0C
`define RCP_REG_RESP   5'h10
`define RCP_REG_SETUP  5'h14
// Control register fields
`define RCP_CTRL_CODEC 1:0
`define RCP_CTRL_LAN   2
`define RCP_CTRL_XBLK  3
// Event status bits
`define RCP_ESR_URQ    6
`define RCP_ESR_CME    5
`define RCP_ESR_EXE    4
`define RCP_ESE_MAX    32'h000000FF
// Codec selections
`define RCP_CODEC_ANSI 2'h0
`define RCP_CODEC_UTF8 2'h1
`define RCP_CODEC_SJIS 2'h2
// Keyword buffer width, twelve characters
`define RCP_KW_W       96
// Character codes
`define RCP_CH_NUL     8'h00
`define RCP_CH_TAB     8'h09
`define RCP_CH_NL      8'h0A
`define RCP_CH_VT      8'h0B
`define RCP_CH_SP      8'h20
`define RCP_CH_STAR    8'h2A
`define RCP_CH_COMMA   8'h2C
`define RCP_CH_COLON   8'h3A
`define RCP_CH_SEMI    8'h3B
`define RCP_CH_QM      8'h3F
`define RCP_CH_AT      8'h40
`define RCP_CH_D0      8'h30
`define RCP_CH_D9      8'h39
`define RCP_CH_UA      8'h41
`define RCP_CH_UZ      8'h5A
`define RCP_CH_LA      8'h61
`define RCP_CH_LZ      8'h7A
`define RCP_CH_CASE    8'h20
// Shift JIS lead byte ranges
`define RCP_SJ_LO1     8'h81
`define RCP_SJ_HI1     8'h9F
`define RCP_SJ_LO2     8'hE0
`define RCP_SJ_HI2     8'hFC
`endif

//--- verilog/rcp_pkg.sv
// Types shared by the remote command parser
package rcp_pkg;
  // Keyword codes from the matcher
  typedef enum logic [3:0] {
    KW_NONE, KW_SYST, KW_USER, KW_KEY, KW_TRIG, KW_SEQ, KW_SOUR, KW_EXT,
    KW_IMM, KW_ON, KW_OFF, KW_RST, KW_ESE, KW_ESR, KW_GOLOC, KW_GOREM
  } rcp_kw_type;
  // Remote/local state: bit 0 remote, bit 1 lockout
  typedef enum logic [1:0] {
    RL_LOCAL = 2'h0, RL_REMOTE = 2'h1, RL_RLOCK = 2'h3, RL_LLOCK = 2'h2
  } rcp_rl_type;
  // Parser phase
  typedef enum logic [1:0] {
    PS_HDR = 2'h0, PS_PAR = 2'h1, PS_SKIP = 2'h3
  } rcp_pst_type;
  // Position in the command tree
  typedef enum logic [3:0] {
    N_ROOT, N_SYS, N_USER, N_KEY, N_TRIG, N_TSRC, N_SRC, N_RST,
    N_ESE, N_ESR, N_GOLOC, N_GOREM, N_ERR
  } rcp_node_type;
endpackage

//--- verilog/rcp_kwmatch.sv
// Keyword matcher: exact short or long form to keyword code
`timescale 1ns/1ps
`include "rcp_defines.svh"
module rcp_kwmatch
  import rcp_pkg::*;
(
  // Upper-case keyword, right-aligned, zero-filled
  input  wire logic [`RCP_KW_W-1:0] kw_in,
  // Matched keyword code
  output rcp_kw_type                kw_out
);
  // Whole-word compare, no partial forms
  function automatic logic hit(input logic [`RCP_KW_W-1:0] k,
                               input logic [`RCP_KW_W-1:0] lf,
                               input logic [`RCP_KW_W-1:0] sf);
    hit = (k == lf) || (k == sf);
  endfunction

  // Keyword table
  always_comb
  begin
    kw_out = KW_NONE;
    if (hit(kw_in, 96'("SYSTEM"), 96'("SYST")))         kw_out = KW_SYST;
    else if (hit(kw_in, 96'("USER"), 96'("USER")))      kw_out = KW_USER;
    else if (hit(kw_in, 96'("KEY"), 96'("KEY")))        kw_out = KW_KEY;
    else if (hit(kw_in, 96'("TRIGGER"), 96'("TRIG")))   kw_out = KW_TRIG;
    else if (hit(kw_in, 96'("SEQUENCE"), 96'("SEQ")))   kw_out = KW_SEQ;
    else if (hit(kw_in, 96'("SOURCE"), 96'("SOUR")))    kw_out = KW_SOUR;
    else if (hit(kw_in, 96'("EXTERNAL"), 96'("EXT")))   kw_out = KW_EXT;
    else if (hit(kw_in, 96'("IMMEDIATE"), 96'("IMM")))  kw_out = KW_IMM;
    else if (hit(kw_in, 96'("ON"), 96'("ON")))          kw_out = KW_ON;
    else if (hit(kw_in, 96'("OFF"), 96'("OFF")))        kw_out = KW_OFF;
    else if (hit(kw_in, 96'("RST"), 96'("RST")))        kw_out = KW_RST;
    else if (hit(kw_in, 96'("ESE"), 96'("ESE")))        kw_out = KW_ESE;
    else if (hit(kw_in, 96'("ESR"), 96'("ESR")))        kw_out = KW_ESR;
    else if (hit(kw_in, 96'("LOC"), 96'("LOC")))        kw_out = KW_GOLOC;
    else if (hit(kw_in, 96'("REM"), 96'("REM")))        kw_out = KW_GOREM;
  end
endmodule

//--- verilog/rcp_top.sv
// Remote command parser with remote/local state and register slave
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "rcp_defines.svh"
// Notes on behaviour
// - Powers up local; any command makes remote.
// - Local request honoured only when parser idle.
// - LAN go-local/go-remote commands switch state.
// - Lockout disables the panel go-local key.
// - Remote-enable falling edge lifts lockout, goes local.
// - User key sets event bit 6, key value.
// - Codec decides which bytes are literal text.
// - Codes 0-9 and 11-32 are white space.
// - Question mark makes a query with response.
// - Conflicting setting discarded, sets event bit 4.
// - Leading asterisk marks a common command.
// - Reset, event enable write, event status read.
// - Colon-separated hierarchical path from root system.
// - Keyword meaning depends on its tree level.
// - Optional keyword may be omitted or given.
// - Short or long form, case ignored.
// - Commas split the parameter list.
// - Semicolon separates; colon after it restarts root.
// - Line ends on new-line or end-or-identify.
module rcp_top
  import rcp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Command byte stream
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_eoi_in,
  output logic             rx_ready_out,
  // Bus management lines and messages
  input  wire logic        ren_in,
  input  wire logic        llo_in,
  input  wire logic        gtl_in,
  // Front panel
  input  wire logic        local_key_in,
  input  wire logic        user_key_stb_in,
  input  wire logic [2:0]  user_key_in,
  // State and settings
  output logic      [1:0]  rl_state_out,
  output logic             trig_ext_out,
  output logic             src_on_out
);
  // Range test for character classes
  function automatic logic in_rng(input logic [7:0] c, input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_rng = (c >= lo) && (c <= hi);
  endfunction

  // Settings and status registers
  rcp_rl_type            rl_r, rl_nxt;     // Remote/local state
  logic [1:0]            codec_r;          // Character encoding
  logic                  lan_r;            // LAN protocol mode
  logic                  xblk_r;           // External trigger unavailable
  logic [7:0]            esr_r, esr_nxt;   // Event status
  logic [7:0]            ese_r;            // Event status enable
  logic [3:0]            ukey_r;           // Last user key, 0 none
  logic                  trig_ext_r;       // Trigger source external
  logic                  src_on_r;         // Source output on
  logic [31:0]           resp_r;           // Query response
  logic                  resp_valid_r;     // Response unread
  logic                  ren_r;            // Remote enable, last cycle
  // Parser registers
  rcp_pst_type           pst_r, pst_nxt;   // Parser phase
  logic [`RCP_KW_W-1:0]  kbuf_r, kbuf_nxt; // Keyword being built
  rcp_node_type          node_r, node_nxt; // Current tree position
  rcp_node_type          base_r, base_nxt; // Path kept after semicolon
  logic                  any_r, any_nxt;   // Command has content
  logic                  com_r, com_nxt;   // Common command
  logic                  at_r, at_nxt;     // LAN switch command
  logic                  qry_r, qry_nxt;   // Query flag
  logic                  hasp_r, hasp_nxt; // First parameter seen
  logic [1:0]            ncom_r, ncom_nxt; // Comma count, saturating
  logic [31:0]           val_r, val_nxt;   // First numeric parameter
  logic                  lit_r;            // Next byte is literal
  logic                  ack_r;            // Bus answer cycle

  // Byte classification
  logic [7:0] ch;
  logic is_lit, is_ws, is_lc, is_alpha, is_dig, is_colon, is_semi;
  logic is_comma, is_qm, is_star, is_at, take, eol, term, sjis_lead;
  logic [7:0] up_ch;
  assign ch        = rx_data_in;
  assign sjis_lead = (codec_r == `RCP_CODEC_SJIS) && !lit_r &&
                     (in_rng(ch, `RCP_SJ_LO1, `RCP_SJ_HI1) ||
                      in_rng(ch, `RCP_SJ_LO2, `RCP_SJ_HI2));
  assign is_lit    = lit_r || ch[7];
  assign is_ws     = !is_lit && (in_rng(ch, `RCP_CH_NUL, `RCP_CH_TAB) ||
                                 in_rng(ch, `RCP_CH_VT, `RCP_CH_SP));
  assign is_lc     = !is_lit && in_rng(ch, `RCP_CH_LA, `RCP_CH_LZ);
  assign is_alpha  = is_lc || (!is_lit && in_rng(ch, `RCP_CH_UA, `RCP_CH_UZ));
  assign is_dig    = !is_lit && in_rng(ch, `RCP_CH_D0, `RCP_CH_D9);
  assign is_colon  = !is_lit && (ch == `RCP_CH_COLON);
  assign is_semi   = !is_lit && (ch == `RCP_CH_SEMI);
  assign is_comma  = !is_lit && (ch == `RCP_CH_COMMA);
  assign is_qm     = !is_lit && (ch == `RCP_CH_QM);
  assign is_star   = !is_lit && (ch == `RCP_CH_STAR);
  assign is_at     = !is_lit && (ch == `RCP_CH_AT);
  assign up_ch     = is_lc ? ch - `RCP_CH_CASE : ch;
  assign rx_ready_out = !resp_valid_r;
  assign take      = rx_valid_in && rx_ready_out;
  assign eol       = take && ((!is_lit && ch == `RCP_CH_NL) || rx_eoi_in);
  assign term      = eol || (take && is_semi);

  // Keyword buffer and matcher
  logic [`RCP_KW_W-1:0] kbuf_app, ksrc;
  logic kempty, kovf;
  rcp_kw_type kw;
  assign kbuf_app = {kbuf_r[`RCP_KW_W-9:0], up_ch};
  assign ksrc     = (take && is_alpha) ? kbuf_app : kbuf_r;
  assign kempty   = (kbuf_r == '0);
  assign kovf     = (kbuf_r[`RCP_KW_W-1 -: 8] != 8'h00);
  rcp_kwmatch u_kw (
    .kw_in  (ksrc),
    .kw_out (kw)
  );

  // Tree step for one keyword
  rcp_node_type nstep;
  always_comb
  begin
    nstep = N_ERR;
    if (com_r)
      nstep = (kw == KW_RST) ? N_RST : (kw == KW_ESE) ? N_ESE :
              (kw == KW_ESR) ? N_ESR : N_ERR;
    else if (at_r)
      nstep = (kw == KW_GOLOC) ? N_GOLOC : (kw == KW_GOREM) ? N_GOREM : N_ERR;
    else
      unique case (node_r)
        N_ROOT: nstep = (kw == KW_SYST) ? N_SYS : (kw == KW_TRIG) ? N_TRIG :
                        (kw == KW_SOUR) ? N_SRC : N_ERR;
        N_SYS:  nstep = (kw == KW_USER) ? N_USER : N_ERR;
        N_USER: nstep = (kw == KW_KEY) ? N_KEY : N_ERR;
        N_TRIG: nstep = (kw == KW_SEQ) ? N_TRIG :
                        (kw == KW_SOUR) ? N_TSRC : N_ERR;
        default: nstep = N_ERR;
      endcase
  end

  // Values as of the terminating byte, last data byte included
  logic in_hdr, in_par, first_p, q, hasp, ptxt;
  logic [31:0] val_app, pv;
  rcp_node_type ex_node;
  rcp_kw_type pk;
  assign in_hdr  = (pst_r == PS_HDR);
  assign in_par  = (pst_r == PS_PAR);
  assign first_p = take && in_par && (ncom_r == 2'h0);
  assign val_app = (val_r << 3) + (val_r << 1) + {24'h000000, ch - `RCP_CH_D0};
  assign q       = qry_r || (take && in_hdr && is_qm);
  assign hasp    = hasp_r || (first_p && (is_alpha || is_dig));
  assign ptxt    = in_par && (ksrc != '0);
  assign pv      = (first_p && is_dig) ? val_app : val_r;
  assign pk      = in_par ? kw : KW_NONE;
  assign ex_node = in_hdr ? nstep : node_r;

  // Parser next state
  always_comb
  begin
    pst_nxt = pst_r; kbuf_nxt = kbuf_r; node_nxt = node_r; base_nxt = base_r;
    any_nxt = any_r; com_nxt = com_r; at_nxt = at_r; qry_nxt = qry_r;
    hasp_nxt = hasp_r; ncom_nxt = ncom_r; val_nxt = val_r;
    if (take && in_hdr)
    begin
      if (is_alpha)
      begin
        kbuf_nxt = kbuf_app;
        any_nxt  = 1'b1;
        if (kovf)
          pst_nxt = PS_SKIP;
      end
      else if (is_star && !any_r)
      begin
        com_nxt = 1'b1;
        any_nxt = 1'b1;
      end
      else if (is_at && !any_r)
      begin
        at_nxt  = 1'b1;
        any_nxt = 1'b1;
        if (!lan_r)
          pst_nxt = PS_SKIP;
      end
      else if (is_colon && !any_r)
      begin
        node_nxt = N_ROOT;
        any_nxt  = 1'b1;
      end
      else if (is_ws && !any_r)
        any_nxt = 1'b0;
      else if (is_colon || is_qm || is_ws)
      begin
        kbuf_nxt = '0;
        node_nxt = nstep;
        if (nstep == N_ERR)
          pst_nxt = PS_SKIP;
        else if (!is_colon)
          pst_nxt = PS_PAR;
        qry_nxt = is_qm;
      end
      else if (!term)
        pst_nxt = PS_SKIP;
    end
    else if (take && in_par)
    begin
      if (is_comma)
        ncom_nxt = ncom_r + {1'b0, ~&ncom_r};
      else if (is_alpha && ncom_r == 2'h0)
      begin
        kbuf_nxt = kbuf_app;
        hasp_nxt = 1'b1;
        if (kovf)
          pst_nxt = PS_SKIP;
      end
      else if (is_dig && ncom_r == 2'h0)
      begin
        val_nxt  = val_app;
        hasp_nxt = 1'b1;
      end
      else if (!(is_ws || is_lit || is_alpha || is_dig || term))
        pst_nxt = PS_SKIP;
    end
    if (term)
    begin
      pst_nxt = PS_HDR; kbuf_nxt = '0; any_nxt = 1'b0; com_nxt = 1'b0;
      at_nxt = 1'b0; qry_nxt = 1'b0; hasp_nxt = 1'b0; ncom_nxt = 2'h0;
      val_nxt = '0;
      if (eol)
        base_nxt = N_ROOT;
      else if (!com_r && !at_r)
        base_nxt = (ex_node == N_KEY) ? N_USER :
                   (ex_node == N_TSRC) ? N_TRIG : N_ROOT;
      node_nxt = base_nxt;
    end
  end

  // Command decode at the terminator
  logic exec, bad, noarg, one, ex_ok, ex_resp, ex_conf, lan_loc, lan_rem;
  logic [31:0] ex_rdata;
  assign exec  = term && any_r && (pst_r != PS_SKIP) && !(in_hdr && nstep == N_ERR);
  assign bad   = term && any_r && !(exec && ex_ok);
  assign noarg = !hasp && (ncom_r == 2'h0);
  assign one   = hasp && (ncom_r == 2'h0);
  always_comb
  begin
    ex_ok = 1'b0; ex_resp = 1'b0; ex_conf = 1'b0; ex_rdata = '0;
    unique case (ex_node)
      N_RST: ex_ok = !q && noarg;
      N_ESE:
      begin
        ex_ok    = q ? noarg : (one && !ptxt && pv <= `RCP_ESE_MAX);
        ex_resp  = q;
        ex_rdata = {24'h000000, ese_r};
      end
      N_ESR:
      begin
        ex_ok    = q && noarg;
        ex_resp  = 1'b1;
        ex_rdata = {24'h000000, esr_r};
      end
      N_KEY:
      begin
        ex_ok    = q && noarg;
        ex_resp  = 1'b1;
        ex_rdata = {28'h0000000, ukey_r};
      end
      N_TSRC:
      begin
        ex_ok    = q ? noarg : (one && (pk == KW_EXT || pk == KW_IMM));
        ex_conf  = !q && pk == KW_EXT && xblk_r;
        ex_resp  = q;
        ex_rdata = {31'h00000000, trig_ext_r};
      end
      N_SRC:
      begin
        ex_ok    = q ? noarg : (one && (pk == KW_ON || pk == KW_OFF || !ptxt));
        ex_resp  = q;
        ex_rdata = {31'h00000000, src_on_r};
      end
      N_GOLOC, N_GOREM: ex_ok = !q && noarg;
      default: ex_ok = 1'b0;
    endcase
  end
  assign lan_loc = exec && ex_ok && ex_node == N_GOLOC && eol && rl_r[0];
  assign lan_rem = exec && ex_ok && ex_node == N_GOREM;

  // Remote/local state next value
  logic busy, ren_fall, loc_ok;
  assign busy     = any_r || !in_hdr || node_r != N_ROOT || base_r != N_ROOT;
  assign ren_fall = ren_r && !ren_in;
  assign loc_ok   = lan_loc || (!busy && !take &&
                    ((local_key_in && rl_r == RL_REMOTE) || (gtl_in && rl_r[0])));
  always_comb
  begin
    rl_nxt = rl_r;
    if (ren_fall)
      rl_nxt = RL_LOCAL;
    else if (llo_in)
      rl_nxt = rcp_rl_type'({1'b1, rl_r[0]});
    else if (loc_ok)
      rl_nxt = rcp_rl_type'({rl_r[1], 1'b0});
    else if (take || lan_rem)
      rl_nxt = rcp_rl_type'({rl_r[1], 1'b1});
  end

  // Event status: setting wins over the read clear
  logic esr_clr;
  assign esr_clr = exec && ex_ok && q && ex_node == N_ESR;
  always_comb
  begin
    esr_nxt = esr_clr ? 8'h00 : esr_r;
    esr_nxt[`RCP_ESR_URQ] = esr_nxt[`RCP_ESR_URQ] | user_key_stb_in;
    esr_nxt[`RCP_ESR_CME] = esr_nxt[`RCP_ESR_CME] | (bad && !ex_conf);
    esr_nxt[`RCP_ESR_EXE] = esr_nxt[`RCP_ESR_EXE] | (exec && ex_conf);
  end

  // Register bus decode
  logic req, bus_wr, bus_rd, do_set, do_rst;
  logic [31:0] rd_mux;
  assign req    = avs_read_in || avs_write_in;
  assign bus_wr = avs_write_in && ack_r && avs_address_in == `RCP_REG_CTRL &&
                  avs_byteenable_in[0];
  assign bus_rd = avs_read_in && ack_r && avs_address_in == `RCP_REG_RESP;
  assign avs_waitrequest_out = req && !ack_r;
  assign rd_mux =
    (avs_address_in == `RCP_REG_CTRL)   ? {28'h0000000, xblk_r, lan_r, codec_r} :
    (avs_address_in == `RCP_REG_STATUS) ? {28'h0000000, resp_valid_r, busy, rl_r} :
    (avs_address_in == `RCP_REG_EVENT)  ? {16'h0000, ese_r, esr_r} :
    (avs_address_in == `RCP_REG_UKEY)   ? {28'h0000000, ukey_r} :
    (avs_address_in == `RCP_REG_RESP)   ? resp_r :
    (avs_address_in == `RCP_REG_SETUP)  ? {30'h00000000, src_on_r, trig_ext_r} :
    32'h00000000;
  assign do_set = exec && ex_ok && !q && !ex_conf;
  assign do_rst = do_set && ex_node == N_RST;

  // Bus answer and control register
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ack_r <= 1'b0; avs_readdata_out <= '0; codec_r <= `RCP_CODEC_ANSI;
      lan_r <= 1'b0; xblk_r <= 1'b0;
    end
    else
    begin
      ack_r <= req && !ack_r;
      if (req && !ack_r)
        avs_readdata_out <= rd_mux;
      if (bus_wr)
        {xblk_r, lan_r, codec_r} <= avs_writedata_in[3:0];
    end
  end

  // State, events, settings and response
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rl_r <= RL_LOCAL; esr_r <= 8'h00; ren_r <= 1'b0; lit_r <= 1'b0;
      ese_r <= 8'h00; ukey_r <= 4'h0; trig_ext_r <= 1'b0; src_on_r <= 1'b0;
      resp_r <= '0; resp_valid_r <= 1'b0;
    end
    else
    begin
      rl_r <= rl_nxt; esr_r <= esr_nxt; ren_r <= ren_in;
      if (take)
        lit_r <= sjis_lead;
      if (user_key_stb_in)
        ukey_r <= {1'b0, user_key_in} + 4'h1;
      else if (do_rst)
        ukey_r <= 4'h0;
      if (do_rst)
        {ese_r, trig_ext_r, src_on_r} <= '0;
      else if (do_set && ex_node == N_ESE)
        ese_r <= pv[7:0];
      else if (do_set && ex_node == N_TSRC)
        trig_ext_r <= (pk == KW_EXT);
      else if (do_set && ex_node == N_SRC)
        src_on_r <= ptxt ? (pk == KW_ON) : (pv != '0);
      if (exec && ex_ok && q && ex_resp)
      begin
        resp_r       <= ex_rdata;
        resp_valid_r <= 1'b1;
      end
      else if (bus_rd)
        resp_valid_r <= 1'b0;
    end
  end

  // Parser registers
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pst_r <= PS_HDR; kbuf_r <= '0; node_r <= N_ROOT; base_r <= N_ROOT;
      {any_r, com_r, at_r, qry_r, hasp_r} <= '0; ncom_r <= 2'h0; val_r <= '0;
    end
    else
    begin
      pst_r <= pst_nxt; kbuf_r <= kbuf_nxt; node_r <= node_nxt; base_r <= base_nxt;
      {any_r, com_r, at_r, qry_r, hasp_r} <= {any_nxt, com_nxt, at_nxt, qry_nxt, hasp_nxt};
      ncom_r <= ncom_nxt; val_r <= val_nxt;
    end
  end

  // Outputs
  assign rl_state_out = rl_r;
  assign trig_ext_out = trig_ext_r;
  assign src_on_out   = src_on_r;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  property p_first_rem;
    rl_r == RL_LOCAL && take && !ren_fall && !llo_in && !loc_ok |=> rl_r == RL_REMOTE;
  endproperty
  a_first_rem: assert property (p_first_rem) else $error("no remote on command");
  property p_busy_loc;
    local_key_in && rl_r == RL_REMOTE && busy && !ren_fall && !llo_in && !lan_loc |=> rl_r[0];
  endproperty
  a_busy_loc: assert property (p_busy_loc) else $error("local taken while busy");
  property p_lock;
    rl_r == RL_RLOCK && local_key_in && !gtl_in && !ren_fall && !lan_loc |=> rl_r == RL_RLOCK;
  endproperty
  a_lock: assert property (p_lock) else $error("panel key left lockout");
  property p_ren;
    ren_fall |=> rl_r == RL_LOCAL;
  endproperty
  a_ren: assert property (p_ren) else $error("lockout not lifted");
  property p_ukey;
    user_key_stb_in |=> esr_r[`RCP_ESR_URQ] && ukey_r == {1'b0, $past(user_key_in)} + 4'h1;
  endproperty
  a_ukey: assert property (p_ukey) else $error("user key not recorded");
  property p_query;
    exec && ex_ok && q |=> resp_valid_r && !rx_ready_out && resp_r == $past(ex_rdata);
  endproperty
  a_query: assert property (p_query) else $error("query gave no response");
  property p_conf;
    exec && ex_conf |=> $stable(trig_ext_r) && esr_r[`RCP_ESR_EXE];
  endproperty
  a_conf: assert property (p_conf) else $error("conflict changed setting");
  property p_badkw;
    take && in_hdr && (is_colon || is_ws) && any_r && !eol && kw == KW_NONE |=> pst_r == PS_SKIP;
  endproperty
  a_badkw: assert property (p_badkw) else $error("bad keyword accepted");
  property p_esr_rd;
    esr_clr && !user_key_stb_in |=> resp_r[7:0] == $past(esr_r) && !esr_r[`RCP_ESR_URQ];
  endproperty
  a_esr_rd: assert property (p_esr_rd) else $error("event read wrong");
  property p_bus;
    req && !ack_r |-> avs_waitrequest_out ##1 (!req || !avs_waitrequest_out);
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
  c_query: cover property (exec && ex_ok && q);
  c_lock: cover property (rl_r == RL_REMOTE ##1 rl_r == RL_RLOCK);
  c_conf: cover property (exec && ex_conf);
  c_ukey: cover property (user_key_stb_in && rl_r[0]);
endmodule

//--- verification/rcp_host.sv
// Controller model that sends command lines to the parser
`timescale 1ns/1ps
module rcp_host (
  // Clock and flow control
  input  wire logic       mclk_in,
  input  wire logic       ready_in,
  // Byte stream toward the parser
  output logic            valid_out,
  output logic [7:0]      data_out,
  output logic            eoi_out
);
  logic r; // Ready as settled before the edge
  initial
  begin
    valid_out = 1'b0;
    data_out  = 8'h00;
    eoi_out   = 1'b0;
  end
  // Send one line; each byte is held until taken, eoi optional on the last
  task send(input string s, input bit e = 1'b0);
    for (int i = 0; i < s.len(); i++)
    begin
      valid_out <= 1'b1;
      data_out  <= s[i];
      eoi_out   <= e && (i == s.len() - 1);
      do
      begin
        @(negedge mclk_in) r = ready_in;
        @(posedge mclk_in);
      end while (!r);
    end
    valid_out <= 1'b0;
    eoi_out   <= 1'b0;
    data_out  <= ~data_out; // Released lines must not keep the last byte
  endtask
endmodule

//--- verification/remote_command_parser_local_remote_test.sv
// Self-checking bench for the remote command parser
`timescale 1ns/1ps
module remote_command_parser_local_remote_test;
  logic clk = 0, nrst = 0, rd = 0, wr = 0, ren = 1, llo = 0, lk = 0, us = 0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0, rdat, rs;
  logic [2:0]  uk = 3'h0, k;
  logic        wq, ws, rv, rdy, eoi, tex, son;
  logic [7:0]  rx;
  logic [1:0]  rls;
  logic [3:0]  ps; // Pin outputs as settled before the edge
  logic [31:0] eq[$], mq[$]; // Expected values and masks
  int          err_count = 0, tests_run = 0, seed = 26;
  always #20 clk = ~clk;
  rcp_top dut (.mclk_in(clk), .nrst_in(nrst), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .rx_valid_in(rv), .rx_data_in(rx),
    .rx_eoi_in(eoi), .rx_ready_out(rdy), .ren_in(ren), .llo_in(llo), .gtl_in(1'b0),
    .local_key_in(lk), .user_key_stb_in(us), .user_key_in(uk), .rl_state_out(rls),
    .trig_ext_out(tex), .src_on_out(son));
  rcp_host host (.mclk_in(clk), .ready_in(rdy), .valid_out(rv), .data_out(rx), .eoi_out(eoi));
  // Bus outputs as settled before each edge
  always @(negedge clk)
  begin
    ws = wq;
    rs = rdat;
    ps = {son, tex, rls};
  end
  // Compare the oldest note when a read completes
  always @(posedge clk)
    if (rd && !ws)
    begin
      tests_run++;
      if ((rs & mq[0]) !== eq[0])
      begin
        err_count++;
        $display("mismatch at %0t: got %h expected %h", $time, rs & mq[0], eq[0]);
      end
      // State and setting pins against the same note
      if ((adr == 5'h04 && ({30'h0, ps[1:0]} & mq[0] & 32'h3) !== (eq[0] & 32'h3)) ||
          (adr == 5'h14 && ({30'h0, ps[3:2]} & mq[0] & 32'h3) !== (eq[0] & 32'h3)))
      begin
        err_count++;
        $display("mismatch at %0t: pins %h expected %h", $time, ps, eq[0]);
      end
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  // One register access held until waitrequest drops
  task acc(input logic w, input logic [4:0] a, input logic [31:0] d, m);
    if (!w)
    begin
      eq.push_back(d);
      mq.push_back(m);
    end
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do @(posedge clk); while (ws !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk); // Idle edge before the next request
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog for a hung handshake
  initial
  begin
    #(40 * 4000);
    err_count++;
    stop_test;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    acc(0, 5'h04, 32'h0, 32'h3);
    host.send("TRIG:SEQ:SOUR EXT\n");
    acc(0, 5'h14, 32'h1, 32'h1);
    acc(0, 5'h04, 32'h1, 32'h3);
    host.send("trigger:source imm;:sour on\n");
    acc(0, 5'h14, 32'h2, 32'h3);
    host.send("*ESE 3\n");
    acc(0, 5'h08, 32'h300, 32'hFF00);
    host.send("*ESE 5", 1'b1);
    acc(0, 5'h08, 32'h500, 32'hFF00);
    $display("test tree done");
    host.send("TRIG:SOURX EXT\n");
    acc(0, 5'h08, 32'h20, 32'h20);
    acc(1, 5'h00, 32'h8, 32'h0);
    host.send("TRIG:SOUR EXT\n");
    acc(0, 5'h08, 32'h10, 32'h10);
    acc(0, 5'h14, 32'h2, 32'h3);
    host.send("SOUR?\n");
    acc(0, 5'h04, 32'h8, 32'h8);
    acc(0, 5'h10, 32'h1, 32'hFFFFFFFF);
    acc(0, 5'h04, 32'h0, 32'h8);
    $display("test errors done");
    k = 3'($random(seed));
    uk <= k;
    us <= 1'b1;
    @(posedge clk);
    us <= 1'b0;
    acc(0, 5'h0C, {29'h0, k} + 32'h1, 32'hF);
    acc(0, 5'h08, 32'h40, 32'h40);
    host.send("*ESR?\n");
    acc(0, 5'h10, 32'h70, 32'hFFFFFFFF);
    host.send("*RST\n");
    acc(0, 5'h08, 32'h0, 32'hFFFF);
    acc(0, 5'h14, 32'h0, 32'h3);
    acc(1, 5'h00, 32'h4, 32'h0);
    host.send("@LOC\n");
    acc(0, 5'h04, 32'h0, 32'h3);
    host.send("SOUR");
    lk <= 1'b1;
    @(posedge clk);
    lk <= 1'b0;
    acc(0, 5'h04, 32'h5, 32'h7);
    host.send(" OFF\n");
    lk <= 1'b1;
    @(posedge clk);
    lk <= 1'b0;
    acc(0, 5'h04, 32'h0, 32'h7);
    host.send("@REM\n");
    acc(0, 5'h04, 32'h1, 32'h3);
    llo <= 1'b1;
    @(posedge clk);
    llo <= 1'b0;
    lk  <= 1'b1;
    @(posedge clk);
    lk <= 1'b0;
    acc(0, 5'h04, 32'h3, 32'h3);
    ren <= 1'b0;
    @(posedge clk);
    acc(0, 5'h04, 32'h0, 32'h3);
    acc(0, 5'h1C, 32'h0, 32'hFFFFFFFF);
    $display("test panel done");
    stop_test;
  end
endmodule
